// ---- rtl/utcfg_pkg.sv ----
// Purpose: constants and types for the serial transceiver timing/config block
// Assumes: 8-bit byte address, 32-bit register data
// Notes:   identity values are arbitrary
package utcfg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_IDLE    = 8'h24;
  localparam logic [7:0] OFS_GUARD   = 8'h28;
  localparam logic [7:0] OFS_RATIO   = 8'h40;
  localparam logic [7:0] OFS_TALLY   = 8'h44;
  localparam logic [7:0] OFS_IRFILT  = 8'h4c;
  localparam logic [7:0] OFS_BIPHASE = 8'h50;
  localparam logic [7:0] OFS_CMD     = 8'h58;
  localparam logic [7:0] OFS_STAT    = 8'h5c;
  localparam logic [7:0] OFS_REV     = 8'hfc;
  localparam int unsigned IDLE_W  = 16;
  localparam int unsigned GUARD_W = 8;
  localparam int unsigned RATIO_W = 11;
  localparam int unsigned TALLY_W = 8;
  localparam int unsigned IRF_W   = 8;
  localparam int unsigned LEN_W   = 4;
  localparam logic [RATIO_W-1:0] RATIO_RST = 11'h174;
  localparam logic [31:0] BIPHASE_RST = 32'h30011004;
  localparam int unsigned B_DRIFT  = 30;
  localparam int unsigned B_RSVD_ONE = 29;
  localparam int unsigned B_RX_POL = 28;
  localparam int unsigned B_RX_LEAD_PATTERN  = 24;
  localparam int unsigned B_RX_LEAD_LENGTH  = 16;
  localparam int unsigned B_TX_POL = 12;
  localparam int unsigned B_TX_LEAD_PATTERN  = 8;
  localparam int unsigned B_TX_LEAD_LENGTH  = 0;
  localparam int unsigned B_ARM    = 0;
  localparam int unsigned B_TOUT   = 0;
  localparam int unsigned B_GUARD  = 1;
  localparam int unsigned B_REV    = 0;
  localparam int unsigned B_FLAV   = 16;
  // arbitrary identity values
  localparam logic [11:0] REV_VALUE  = 12'h001;
  localparam logic [3:0]  FLAV_VALUE = 4'h0;
  localparam logic [TALLY_W-1:0] TALLY_MAX = 8'hff;
  typedef enum logic [1:0] {
    LEAD_ALL_ONE  = 2'h0,
    LEAD_ALL_ZERO = 2'h1,
    LEAD_ZERO_ONE = 2'h2,
    LEAD_ONE_ZERO = 2'h3
  } utcfg_lead_t;
  typedef struct packed {
    logic              drift;
    logic              rx_pol;
    utcfg_lead_t       rx_pat;
    logic [LEN_W-1:0]  rx_len;
    logic              tx_pol;
    utcfg_lead_t       tx_pat;
    logic [LEN_W-1:0]  tx_len;
  } utcfg_biphase_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } utcfg_bus_t;
  typedef enum logic [1:0] {
    TXL_IDLE = 2'b01,
    TXL_RUN  = 2'b10
  } utcfg_txl_t;
endpackage

// ---- rtl/utcfg_core.sv ----
// Purpose: idle time-out, guard gap, card clock divider, error tally, biphase config
// Assumes: strobes and event inputs synchronous to i_clk
// Notes:   bit tick is one cycle wide per bit period
//
// Contract
// - idle limit zero keeps time-out off, never flagged
// - idle limit 1..65535 times out after limit bit periods
// - guard zero off; 1..255 holds guard for count bit periods
// - card mode with ratio zero gives no bit tick at all
// - card mode bit tick is card clock divided by ratio
// - card errors counted into read-only eight-bit tally
// - reading the tally register clears it
// - infrared filter value drives the demodulator filter setting
// - drift bit enables drift recovery in the receiver
// - polarity bit per direction inverts biphase transition mapping
// - receive lead pattern selects detected pattern
// - transmit lead pattern selects generated pattern
// - receive lead length zero skips detection
// - receive lead length 1..15 bit periods expected
// - transmit lead length zero sends no lead
// - transmit lead length 1..15 bit periods sent
// - revision and flavour fields read only, no effect
// - time-out flag rises once idle delay elapsed after arm
`timescale 1ns/100ps
module utcfg_core
  import utcfg_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire utcfg_pkg::utcfg_bus_t  i_bus,
  output logic [utcfg_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                   i_card_mode,
  input  wire logic                   i_card_clk_tick,
  input  wire logic                   i_uart_bit_tick,
  input  wire logic                   i_card_error,
  input  wire logic                   i_tx_char_done,
  input  wire logic                   i_tx_frame_start,
  input  wire logic                   i_rx_bit_valid,
  input  wire logic                   i_rx_first_half,
  output logic                        o_bit_tick,
  output logic                        o_rx_timeout,
  output logic                        o_tx_guard_busy,
  output logic [utcfg_pkg::IRF_W-1:0] o_irda_filter,
  output utcfg_pkg::utcfg_biphase_t   o_biphase,
  output logic                        o_tx_lead_active,
  output logic                        o_tx_lead_first_half,
  output logic                        o_rx_lead_found
);
  import utcfg_pkg::*;

  logic [IDLE_W-1:0]  rx_idle_limit_q;
  logic [GUARD_W-1:0] tx_guard_count_q;
  logic [RATIO_W-1:0] smartcard_clock_ratio_q;
  logic [TALLY_W-1:0] smartcard_error_tally_q;
  logic [IRF_W-1:0]   irda_filter_q;
  utcfg_biphase_t     biphase_q;
  logic [RATIO_W-1:0] div_cnt_q;
  logic               bit_tick;
  logic               wr_cmd;
  logic               arm;
  logic               armed_q;
  logic [IDLE_W-1:0]  idle_cnt_q;
  logic               timeout_q;
  logic [GUARD_W-1:0] guard_cnt_q;
  utcfg_txl_t         txl_q;
  logic [LEN_W-1:0]   txl_cnt_q;
  logic               txl_bit;
  logic [LEN_W-1:0]   rxl_cnt_q;
  logic               rx_bit;
  logic               rx_expect;
  logic               rd_tally;
  logic               found_q;
  logic [DATA_W-1:0]  rdata_d;

  // register writes
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_idle_limit_q        <= '0;
      tx_guard_count_q       <= '0;
      smartcard_clock_ratio_q <= RATIO_RST;
      irda_filter_q          <= '0;
      biphase_q.drift        <= BIPHASE_RST[B_DRIFT];
      biphase_q.rx_pol       <= BIPHASE_RST[B_RX_POL];
      biphase_q.rx_pat       <= utcfg_lead_t'(BIPHASE_RST[B_RX_LEAD_PATTERN+:2]);
      biphase_q.rx_len       <= BIPHASE_RST[B_RX_LEAD_LENGTH+:LEN_W];
      biphase_q.tx_pol       <= BIPHASE_RST[B_TX_POL];
      biphase_q.tx_pat       <= utcfg_lead_t'(BIPHASE_RST[B_TX_LEAD_PATTERN+:2]);
      biphase_q.tx_len       <= BIPHASE_RST[B_TX_LEAD_LENGTH+:LEN_W];
    end
    else if (i_bus.wr)
    begin
      case (i_bus.addr)
        OFS_IDLE:    rx_idle_limit_q <= i_bus.wdata[IDLE_W-1:0];
        OFS_GUARD:   tx_guard_count_q <= i_bus.wdata[GUARD_W-1:0];
        OFS_RATIO:   smartcard_clock_ratio_q <= i_bus.wdata[RATIO_W-1:0];
        OFS_IRFILT:  irda_filter_q <= i_bus.wdata[IRF_W-1:0];
        OFS_BIPHASE:
        begin
          biphase_q.drift  <= i_bus.wdata[B_DRIFT];
          biphase_q.rx_pol <= i_bus.wdata[B_RX_POL];
          biphase_q.rx_pat <= utcfg_lead_t'(i_bus.wdata[B_RX_LEAD_PATTERN+:2]);
          biphase_q.rx_len <= i_bus.wdata[B_RX_LEAD_LENGTH+:LEN_W];
          biphase_q.tx_pol <= i_bus.wdata[B_TX_POL];
          biphase_q.tx_pat <= utcfg_lead_t'(i_bus.wdata[B_TX_LEAD_PATTERN+:2]);
          biphase_q.tx_len <= i_bus.wdata[B_TX_LEAD_LENGTH+:LEN_W];
        end
        default:
        begin
        end
      endcase
    end
  end

  assign o_irda_filter = irda_filter_q;
  assign o_biphase     = biphase_q;
  assign wr_cmd = i_bus.wr && (i_bus.addr == OFS_CMD);
  assign arm    = wr_cmd && i_bus.wdata[B_ARM];
  assign rd_tally = i_bus.rd && (i_bus.addr == OFS_TALLY);

  // card clock divider and bit period select
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      div_cnt_q <= '0;
    else if (!i_card_mode || smartcard_clock_ratio_q == '0)
      div_cnt_q <= '0;
    else if (i_card_clk_tick)
    begin
      if (div_cnt_q >= smartcard_clock_ratio_q - 11'h001)
        div_cnt_q <= '0;
      else
        div_cnt_q <= div_cnt_q + 11'h001;
    end
  end

  always_comb
  begin
    if (i_card_mode)
      bit_tick = i_card_clk_tick && smartcard_clock_ratio_q != '0
                 && div_cnt_q >= smartcard_clock_ratio_q - 11'h001;
    else
      bit_tick = i_uart_bit_tick;
  end
  assign o_bit_tick = bit_tick;

  // receive idle time-out
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      armed_q    <= 1'b0;
      idle_cnt_q <= '0;
      timeout_q  <= 1'b0;
    end
    else if (arm)
    begin
      armed_q    <= rx_idle_limit_q != '0;
      idle_cnt_q <= '0;
      timeout_q  <= 1'b0;
    end
    else if (rx_idle_limit_q == '0)
    begin
      armed_q   <= 1'b0;
      timeout_q <= 1'b0;
    end
    else if (armed_q && bit_tick)
    begin
      if (idle_cnt_q + 16'h0001 >= rx_idle_limit_q)
      begin
        timeout_q <= 1'b1;
        armed_q   <= 1'b0;
      end
      idle_cnt_q <= idle_cnt_q + 16'h0001;
    end
  end
  assign o_rx_timeout = timeout_q;

  // transmit guard gap
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      guard_cnt_q <= '0;
    else if (i_tx_char_done)
      guard_cnt_q <= tx_guard_count_q;
    else if (bit_tick && guard_cnt_q != '0)
      guard_cnt_q <= guard_cnt_q - 8'h01;
  end
  assign o_tx_guard_busy = guard_cnt_q != '0;

  // card error tally, an error in the read cycle survives the clear
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      smartcard_error_tally_q <= '0;
    else if (rd_tally)
      smartcard_error_tally_q <= {{(TALLY_W-1){1'b0}}, i_card_error};
    else if (i_card_error && smartcard_error_tally_q != TALLY_MAX)
      smartcard_error_tally_q <= smartcard_error_tally_q + 8'h01;
  end

  // pattern bit for a lead position
  function automatic logic lead_bit(input utcfg_lead_t pat,
                                    input logic odd);
    case (pat)
      LEAD_ALL_ONE:  lead_bit = 1'b1;
      LEAD_ALL_ZERO: lead_bit = 1'b0;
      LEAD_ZERO_ONE: lead_bit = odd;
      LEAD_ONE_ZERO: lead_bit = ~odd;
      default:       lead_bit = 1'b1;
    endcase
  endfunction

  // transmit lead generator
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      txl_q     <= TXL_IDLE;
      txl_cnt_q <= '0;
    end
    else
    begin
      case (txl_q)
        TXL_IDLE:
          if (i_tx_frame_start && biphase_q.tx_len != '0)
          begin
            txl_q     <= TXL_RUN;
            txl_cnt_q <= '0;
          end
        TXL_RUN:
          if (bit_tick)
          begin
            if (txl_cnt_q + 4'h1 >= biphase_q.tx_len)
              txl_q <= TXL_IDLE;
            txl_cnt_q <= txl_cnt_q + 4'h1;
          end
        default:
          txl_q <= TXL_IDLE;
      endcase
    end
  end
  assign txl_bit = lead_bit(biphase_q.tx_pat, txl_cnt_q[0]);
  assign o_tx_lead_active = txl_q == TXL_RUN;
  assign o_tx_lead_first_half = txl_bit ^ biphase_q.tx_pol;

  // receive lead detector
  assign rx_bit    = i_rx_first_half ^ biphase_q.rx_pol;
  assign rx_expect = lead_bit(biphase_q.rx_pat, rxl_cnt_q[0]);
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rxl_cnt_q <= '0;
      found_q   <= 1'b0;
    end
    else
    begin
      found_q <= 1'b0;
      if (biphase_q.rx_len == '0)
        rxl_cnt_q <= '0;
      else if (i_rx_bit_valid)
      begin
        if (rx_bit != rx_expect)
          rxl_cnt_q <= '0;
        else if (rxl_cnt_q + 4'h1 >= biphase_q.rx_len)
        begin
          rxl_cnt_q <= '0;
          found_q   <= 1'b1;
        end
        else
          rxl_cnt_q <= rxl_cnt_q + 4'h1;
      end
    end
  end
  assign o_rx_lead_found = found_q;

  // read mux
  always_comb
  begin
    rdata_d = '0;
    case (i_bus.addr)
      OFS_IDLE:    rdata_d[IDLE_W-1:0] = rx_idle_limit_q;
      OFS_GUARD:   rdata_d[GUARD_W-1:0] = tx_guard_count_q;
      OFS_RATIO:   rdata_d[RATIO_W-1:0] = smartcard_clock_ratio_q;
      OFS_TALLY:   rdata_d[TALLY_W-1:0] = smartcard_error_tally_q;
      OFS_IRFILT:  rdata_d[IRF_W-1:0] = irda_filter_q;
      OFS_BIPHASE:
      begin
        rdata_d[B_DRIFT]         = biphase_q.drift;
        rdata_d[B_RSVD_ONE]      = BIPHASE_RST[B_RSVD_ONE];
        rdata_d[B_RX_POL]        = biphase_q.rx_pol;
        rdata_d[B_RX_LEAD_PATTERN+:2]      = biphase_q.rx_pat;
        rdata_d[B_RX_LEAD_LENGTH+:LEN_W]  = biphase_q.rx_len;
        rdata_d[B_TX_POL]        = biphase_q.tx_pol;
        rdata_d[B_TX_LEAD_PATTERN+:2]      = biphase_q.tx_pat;
        rdata_d[B_TX_LEAD_LENGTH+:LEN_W]  = biphase_q.tx_len;
      end
      OFS_STAT:
      begin
        rdata_d[B_TOUT]  = timeout_q;
        rdata_d[B_GUARD] = o_tx_guard_busy;
      end
      OFS_REV:
      begin
        rdata_d[B_REV+:12] = REV_VALUE;
        rdata_d[B_FLAV+:4] = FLAV_VALUE;
      end
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rdata <= '0;
    else if (i_bus.rd)
      o_rdata <= rdata_d;
    else
      o_rdata <= '0;
  end

  // checks
  sequence s_arm_zero;
    arm && rx_idle_limit_q == '0;
  endsequence
  property p_idle_off;
    @(posedge i_clk) disable iff (!i_rst_b)
    s_arm_zero |=> !timeout_q [*4];
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("time-out with zero limit");

  property p_idle_one;
    @(posedge i_clk) disable iff (!i_rst_b)
    armed_q && bit_tick && rx_idle_limit_q == 16'h0001 && !arm
      |=> timeout_q;
  endproperty
  a_idle_one: assert property (p_idle_one) else $error("limit one not honoured");

  property p_arm_clears;
    @(posedge i_clk) disable iff (!i_rst_b)
    arm |=> !timeout_q;
  endproperty
  a_arm_clears: assert property (p_arm_clears) else $error("arm left flag set");

  property p_guard_load;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_tx_char_done |=> o_tx_guard_busy == ($past(tx_guard_count_q) != '0);
  endproperty
  a_guard_load: assert property (p_guard_load) else $error("guard start wrong");

  property p_ratio_zero;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_card_mode && smartcard_clock_ratio_q == '0 |-> !o_bit_tick;
  endproperty
  a_ratio_zero: assert property (p_ratio_zero) else $error("tick with zero ratio");

  property p_ratio_one;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_card_mode && smartcard_clock_ratio_q == 11'h001 |-> o_bit_tick == i_card_clk_tick;
  endproperty
  a_ratio_one: assert property (p_ratio_one) else $error("ratio one divide wrong");

  property p_tally_clear;
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_tally && !i_card_error |=> smartcard_error_tally_q == '0;
  endproperty
  a_tally_clear: assert property (p_tally_clear) else $error("tally not cleared");

  property p_tally_inc;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_card_error && !rd_tally && smartcard_error_tally_q != TALLY_MAX
      |=> smartcard_error_tally_q == $past(smartcard_error_tally_q) + 8'h01;
  endproperty
  a_tally_inc: assert property (p_tally_inc) else $error("tally missed error");

  property p_tx_lead_off;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_tx_frame_start && !o_tx_lead_active && biphase_q.tx_len == '0 |=> !o_tx_lead_active;
  endproperty
  a_tx_lead_off: assert property (p_tx_lead_off) else $error("lead with zero length");

  property p_rx_lead_off;
    @(posedge i_clk) disable iff (!i_rst_b)
    biphase_q.rx_len == '0 && $past(biphase_q.rx_len) == '0 |-> !o_rx_lead_found;
  endproperty
  a_rx_lead_off: assert property (p_rx_lead_off) else $error("lead found while off");
endmodule

// ---- test/utcfg_peer.sv ----
// Purpose: far-side source of baud ticks and card clock ticks
// Assumes: ticks synchronous to i_clk, one cycle wide
// Notes:   baud tick every 4 cycles, card tick every 2, both still while disabled
`timescale 1ns/100ps
module utcfg_peer
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_en,
  output logic      o_uart_bit_tick,
  output logic      o_card_clk_tick
);
  logic [1:0] div_q;

  // divider restarts from zero on every enable
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      div_q           <= 2'h0;
      o_uart_bit_tick <= 1'b0;
      o_card_clk_tick <= 1'b0;
    end
    else
    begin
      div_q           <= i_en ? div_q + 2'h1 : 2'h0;
      o_uart_bit_tick <= i_en && (div_q == 2'h3);
      o_card_clk_tick <= i_en && div_q[0];
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the timing and config block
// Assumes: register port with one-cycle read latency
// Notes:   bit ticks come from the peer model
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  import utcfg_pkg::*;
  logic                i_clk, i_rst_b, card_mode, card_err, char_done, frame_start;
  logic                rx_valid, rx_fh, peer_en, uart_tick, card_tick;
  logic                bit_tick, rx_timeout, guard_busy, lead_act, lead_fh, lead_found;
  utcfg_bus_t          bus;
  logic [DATA_W-1:0]   rdata, d;
  logic [IRF_W-1:0]    irf;
  utcfg_biphase_t      bph;
  logic [ADDR_W-1:0]   ofs [8];
  logic [DATA_W-1:0]   rstv [8];
  logic [DATA_W-1:0]   mask [8];
  int                  error_cnt, checks_done, cyc, n, found_cnt;

  utcfg_core i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata),
    .i_card_mode(card_mode), .i_card_clk_tick(card_tick), .i_uart_bit_tick(uart_tick),
    .i_card_error(card_err), .i_tx_char_done(char_done), .i_tx_frame_start(frame_start),
    .i_rx_bit_valid(rx_valid), .i_rx_first_half(rx_fh), .o_bit_tick(bit_tick),
    .o_rx_timeout(rx_timeout), .o_tx_guard_busy(guard_busy), .o_irda_filter(irf),
    .o_biphase(bph), .o_tx_lead_active(lead_act), .o_tx_lead_first_half(lead_fh),
    .o_rx_lead_found(lead_found));
  utcfg_peer i_peer (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_en(peer_en),
    .o_uart_bit_tick(uart_tick), .o_card_clk_tick(card_tick));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cyc++;
    if (lead_found === 1'b1)
      found_cnt++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t run too long", $time);
      tally_and_finish();
    end
  end

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge i_clk);
    bus.addr  <= a;
    bus.wdata <= v;
    bus.wr    <= 1'b1;
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge i_clk);
    bus.rd <= 1'b0;
    @(posedge i_clk);
    v = rdata;
  endtask

  // cycles up to and including the next bit tick land in n
  task automatic wait_tick;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (bit_tick !== 1'b1 && n < 200);
  endtask

  task automatic end_test(input string s);
    $display("test %s done, mismatches so far %0d", s, error_cnt);
  endtask

  function automatic logic pat_bit(input int p, input int k);
    return (p == 0) || (p == 2 && k % 2 == 1) || (p == 3 && k % 2 == 0);
  endfunction

  task automatic feed_rx(input int p, input int pol, input int len);
    reg_wr(OFS_BIPHASE, (p << 24) | (len << 16) | (pol << 28));
    found_cnt = 0;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge i_clk);
      rx_valid <= 1'b1;
      rx_fh    <= pat_bit(p, k) ^ pol[0];
    end
    @(posedge i_clk);
    rx_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  initial
  begin
    {card_mode, card_err, char_done, frame_start, rx_valid, rx_fh, peer_en} = '0;
    bus = '0;
    i_rst_b = 1'b0;
    ofs  = '{OFS_IDLE, OFS_GUARD, OFS_RATIO, OFS_TALLY, OFS_IRFILT, OFS_BIPHASE, OFS_REV, 8'h30};
    rstv = '{32'h0, 32'h0, 32'h174, 32'h0, 32'h0, 32'h30011004,
             {12'h0, FLAV_VALUE, 4'h0, REV_VALUE}, 32'h0};
    mask = '{32'hffff, 32'hff, 32'h7ff, 32'h0, 32'hff, 32'h730f130f, rstv[6], 32'h0};
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      reg_rd(ofs[i], d);
      `CHK(d, rstv[i])
    end
    // drift set here by the all-ones write, checked in the readback and on o_biphase
    for (int i = 0; i < 8; i++)
    begin
      reg_wr(ofs[i], 32'hffffffff);
      reg_rd(ofs[i], d);
      `CHK(d, mask[i])
    end
    `CHK(bph, 15'h7fff)
    reg_wr(OFS_IRFILT, 32'h5a);
    @(posedge i_clk);
    `CHK(irf, 8'h5a)
    end_test("registers");
    reg_wr(OFS_IDLE, 32'h0);
    reg_wr(OFS_CMD, 32'h1);
    peer_en <= 1'b1;
    repeat (6) wait_tick();
    `CHK(rx_timeout, 1'b0)
    peer_en <= 1'b0;
    reg_wr(OFS_IDLE, 32'h3);
    reg_wr(OFS_CMD, 32'h1);
    peer_en <= 1'b1;
    repeat (2) wait_tick();
    #1 `CHK(rx_timeout, 1'b0)
    wait_tick();
    #1 `CHK(rx_timeout, 1'b1)
    reg_rd(OFS_STAT, d);
    `CHK(d[B_TOUT], 1'b1)
    reg_wr(OFS_CMD, 32'h1);
    #1 `CHK(rx_timeout, 1'b0)
    reg_wr(OFS_IDLE, 32'h1);
    reg_wr(OFS_CMD, 32'h1);
    #1 `CHK(rx_timeout, 1'b0)
    wait_tick();
    #1 `CHK(rx_timeout, 1'b1)
    peer_en <= 1'b0;
    end_test("time-out");
    reg_wr(OFS_GUARD, 32'h2);
    @(posedge i_clk);
    char_done <= 1'b1;
    @(posedge i_clk);
    char_done <= 1'b0;
    peer_en   <= 1'b1;
    #1 `CHK(guard_busy, 1'b1)
    wait_tick();
    #1 `CHK(guard_busy, 1'b1)
    wait_tick();
    #1 `CHK(guard_busy, 1'b0)
    peer_en <= 1'b0;
    reg_wr(OFS_GUARD, 32'h0);
    @(posedge i_clk);
    char_done <= 1'b1;
    @(posedge i_clk);
    char_done <= 1'b0;
    @(posedge i_clk);
    `CHK(guard_busy, 1'b0)
    end_test("guard");
    card_mode <= 1'b1;
    for (int r = 1; r < 4; r += 2)
    begin
      reg_wr(OFS_RATIO, r);
      peer_en <= 1'b1;
      wait_tick();
      wait_tick();
      `CHK(n, 2 * r)
      peer_en <= 1'b0;
    end
    reg_wr(OFS_RATIO, 32'h0);
    peer_en <= 1'b1;
    n = 0;
    repeat (40)
    begin
      @(posedge i_clk);
      if (bit_tick === 1'b1)
        n++;
    end
    `CHK(n, 0)
    peer_en   <= 1'b0;
    card_mode <= 1'b0;
    end_test("card clock");
    @(posedge i_clk);
    card_err <= 1'b1;
    repeat (3) @(posedge i_clk);
    card_err <= 1'b0;
    reg_rd(OFS_TALLY, d);
    `CHK(d, 32'h3)
    reg_rd(OFS_TALLY, d);
    `CHK(d, 32'h0)
    end_test("error tally");
    for (int p = 0; p < 5; p++)
    begin
      reg_wr(OFS_BIPHASE, (p < 4) ? ((p << 8) | ((p % 2) << 12) | 4) : 0);
      @(posedge i_clk);
      frame_start <= 1'b1;
      @(posedge i_clk);
      frame_start <= 1'b0;
      peer_en     <= 1'b1;
      for (int k = 0; k < 4 && p < 4; k++)
      begin
        wait_tick();
        `CHK(lead_act, 1'b1)
        `CHK(lead_fh, pat_bit(p, k) ^ p[0])
      end
      #1 `CHK(lead_act, 1'b0)
      peer_en <= 1'b0;
    end
    end_test("transmit lead");
    for (int p = 0; p < 4; p++)
    begin
      feed_rx(p, p / 2, 3);
      `CHK(found_cnt, 1)
    end
    feed_rx(0, 0, 0);
    `CHK(found_cnt, 0)
    end_test("receive lead");
    tally_and_finish();
  end
endmodule
